/* File: bench/dpram_device_model.sv */
// Behavioural model of the memory device as seen from one port
`timescale 1ns/10ps
module dpram_device_model (
  input  logic [15:0] addr,
  input  logic        port_select_n,
  input  logic        token_select_n,
  input  logic        write_strobe_n,
  input  logic        output_enable_n,
  input  logic        high_byte_select_n,
  input  logic        low_byte_select_n,
  input  logic [15:0] data_out,
  input  logic        peer_busy,
  input  logic        peer_mbox_write,
  input  logic [7:0]  peer_tokens,
  output logic [15:0] data_in,
  output logic        contention_n,
  output logic        mailbox_irq_n
);
  logic [15:0] mem [0:65535];
  logic [15:0] val;
  logic [7:0]  mine = 8'h00;
  logic        irq = 1'b0;
  logic        rd;
  assign contention_n = !peer_busy;
  assign mailbox_irq_n = !irq;
  assign val = !token_select_n ? {16{!mine[addr[2:0]]}} : mem[addr];
  assign rd = !output_enable_n && (!port_select_n || !token_select_n);
  assign data_in[15:8] = rd && !(high_byte_select_n && token_select_n) ? val[15:8] : ~val[15:8];
  assign data_in[7:0] = rd && !(low_byte_select_n && token_select_n) ? val[7:0] : ~val[7:0];
  always @(posedge write_strobe_n) begin
    if (!port_select_n && !high_byte_select_n)
      mem[addr][15:8] = data_out[15:8];
    if (!port_select_n && !low_byte_select_n)
      mem[addr][7:0] = data_out[7:0];
    if (!token_select_n && !data_out[0] && !peer_tokens[addr[2:0]])
      mine[addr[2:0]] = 1'b1;
    if (!token_select_n && data_out[0])
      mine[addr[2:0]] = 1'b0;
  end
  always @(posedge peer_mbox_write)
    irq = 1'b1;
  always @(posedge output_enable_n) begin
    if (!port_select_n && addr == 16'hfffe && !peer_busy)
      irq = 1'b0;
  end
endmodule // dpram_device_model

/* File: bench/dpram_host_asserts.sv */
// Pin and handshake checks for the port controller
`timescale 1ns/10ps
module dpram_host_asserts (
  input logic        clk,
  input logic        rstn,
  input logic        cmd_valid,
  input logic        cmd_ready,
  input logic        cmd_write,
  input logic        rsp_valid,
  input logic [15:0] addr,
  input logic        port_select_n,
  input logic        token_select_n,
  input logic        write_strobe_n,
  input logic        output_enable_n,
  input logic        high_byte_select_n,
  input logic        low_byte_select_n,
  input logic [15:0] data_out,
  input logic        data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence take_wr;
    cmd_valid && cmd_ready && cmd_write;
  endsequence
  sequence take_rd;
    cmd_valid && cmd_ready && !cmd_write;
  endsequence
  sequence strobe_pulse;
    !write_strobe_n [*5] ##1 write_strobe_n;
  endsequence
  a_write_select: assert property (!write_strobe_n |-> !token_select_n ||
    (!port_select_n && !(high_byte_select_n && low_byte_select_n))) else $error("bad write");
  a_addr_hold: assert property (!$stable(addr) |-> write_strobe_n)
    else $error("address moved during write");
  a_pulse_width: assert property ($fell(write_strobe_n) |-> strobe_pulse)
    else $error("write pulse length");
  a_data_setup: assert property ($rose(write_strobe_n) |-> $stable(data_out) &&
    $past(data_oe, 2)) else $error("data setup");
  a_read_enable: assert property (!output_enable_n |-> write_strobe_n && !data_oe)
    else $error("read with strobe or drive");
  a_read_select: assert property (!output_enable_n |-> port_select_n != token_select_n)
    else $error("read select");
  a_select_excl: assert property (port_select_n || token_select_n)
    else $error("both selects low");
  a_write_done: assert property (take_wr |-> ##10 rsp_valid)
    else $error("write answer late");
  a_read_done: assert property (take_rd |-> ##14 rsp_valid)
    else $error("read answer late");
endmodule // dpram_host_asserts
bind dpram_port_host dpram_host_asserts dpram_host_asserts_inst (.*);

/* File: bench/dpram_port_host_test.sv */
// Self-checking bench for the port controller
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
module dpram_port_host_test;
  logic        clk, rstn, cmd_valid, cmd_write, cmd_token, cmd_set_token;
  logic [15:0] cmd_addr, cmd_wdata;
  logic [1:0]  cmd_byte_en;
  logic        peer_busy, peer_mbox_write;
  logic [7:0]  peer_tokens;
  wire         cmd_ready, rsp_valid, rsp_contended, rsp_token_won, mbox_irq;
  wire  [15:0] rsp_rdata, addr, data_in, data_out;
  wire         contention_seen, port_select_n, token_select_n, write_strobe_n;
  wire         output_enable_n, high_byte_select_n, low_byte_select_n;
  wire         data_oe, contention_n, mailbox_irq_n;
  int          miscompares = 0, comparisons = 0, cycles = 0;
  dpram_port_host dpram_port_host_inst (.*);
  dpram_device_model dpram_device_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end
  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task run(input logic w, t, input logic [15:0] a, d, input logic [1:0] be, input logic s);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    {cmd_valid, cmd_write, cmd_token, cmd_set_token} <= {1'b1, w, t, s};
    {cmd_addr, cmd_wdata, cmd_byte_en} <= {a, d, be};
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    if (rsp_valid !== 1'b1)
      cmp(1'b0, 1'b1);
  endtask
  task peer_irq;
    @(posedge clk);
    peer_mbox_write <= 1'b1;
    @(posedge clk);
    peer_mbox_write <= 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_mem;
    run(1, 0, 16'h0010, 16'h1234, 2'b11, 0);
    run(1, 0, 16'h0010, 16'habcd, 2'b10, 0);
    run(0, 0, 16'h0010, 16'h0000, 2'b11, 0);
    cmp(rsp_rdata, 16'hab34);
    cmp(rsp_contended, 1'b0);
  endtask
  task test_mbox;
    peer_irq;
    cmp(mbox_irq, 1'b1);
    run(0, 0, `RIGHT_MBOX_ADDR, 16'h0000, 2'b11, 0);
    repeat (5) @(negedge clk);
    cmp(mbox_irq, 1'b1);
    run(0, 0, `LEFT_MBOX_ADDR, 16'h0000, 2'b11, 0);
    repeat (5) @(negedge clk);
    cmp(mbox_irq, 1'b0);
  endtask
  task test_busy;
    @(posedge clk);
    peer_busy <= 1'b1;
    peer_irq;
    cmp(contention_seen, 1'b1);
    run(0, 0, `LEFT_MBOX_ADDR, 16'h0000, 2'b11, 0);
    cmp(rsp_contended, 1'b1);
    repeat (5) @(negedge clk);
    cmp(mbox_irq, 1'b1);
    @(posedge clk);
    peer_busy <= 1'b0;
    run(0, 0, `LEFT_MBOX_ADDR, 16'h0000, 2'b11, 0);
    repeat (5) @(negedge clk);
    cmp(mbox_irq, 1'b0);
  endtask
  task test_token;
    run(0, 1, 16'h000b, 16'h0000, 2'b00, 0);
    cmp(rsp_token_won, 1'b0);
    cmp(rsp_rdata, 16'hffff);
    run(1, 1, 16'h000b, 16'h0000, 2'b00, 1);
    run(0, 1, 16'h0003, 16'h0000, 2'b00, 0);
    cmp(rsp_token_won, 1'b1);
    cmp(rsp_rdata, 16'h0000);
    run(1, 1, 16'h0005, 16'h0000, 2'b00, 1);
    run(0, 1, 16'h0005, 16'h0000, 2'b00, 0);
    cmp(rsp_token_won, 1'b0);
    run(1, 1, 16'h0003, 16'h0000, 2'b00, 0);
    run(0, 1, 16'h0003, 16'h0000, 2'b00, 0);
    cmp(rsp_token_won, 1'b0);
  endtask
  initial begin
    {rstn, cmd_valid, cmd_write, cmd_token, cmd_set_token} = 5'h00;
    {cmd_addr, cmd_wdata, cmd_byte_en} = 34'h0;
    {peer_busy, peer_mbox_write} = 2'b00;
    peer_tokens = 8'h20;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    test_mem;
    test_mbox;
    test_busy;
    test_token;
    final_report;
  end
endmodule // dpram_port_host_test

/* File: core/dpram_port_host.v */
// Controller that drives one port of the dual-port memory from a user command port
//--------------------------------------------------------------------------
// Summary of operation
//--------------------------------------------------------------------------
// Summary of operation
// - Strobe held high while address changes
// - Stretch strobe write when output enable low
// - Data stable setup time before write end
// - Memory read: select and output enable low
// - Token read: token select, port select high
// - Delay every access until the contention flag settles
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
module dpram_port_host (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire                 cmd_valid,
  output wire                 cmd_ready,
  input  wire                 cmd_write,
  input  wire                 cmd_token,
  input  wire [`ADDR_W-1:0]   cmd_addr,
  input  wire [`DATA_W-1:0]   cmd_wdata,
  input  wire [1:0]           cmd_byte_en,
  input  wire                 cmd_set_token,
  output reg                  rsp_valid,
  output reg  [`DATA_W-1:0]   rsp_rdata,
  output reg                  rsp_contended,
  output reg                  rsp_token_won,
  output wire                 mbox_irq,
  output wire                 contention_seen,
  output reg  [`ADDR_W-1:0]   addr,
  output reg                  port_select_n,
  output reg                  token_select_n,
  output reg                  write_strobe_n,
  output reg                  output_enable_n,
  output reg                  high_byte_select_n,
  output reg                  low_byte_select_n,
  input  wire [`DATA_W-1:0]   data_in,
  output reg  [`DATA_W-1:0]   data_out,
  output reg                  data_oe,
  input  wire                 contention_n,
  input  wire                 mailbox_irq_n
);
  //------------------------------------------------------------------------
  // Timing counts
  //------------------------------------------------------------------------
  localparam integer settle_int = `CYC_UP(`SELECT_TO_FLAG_PS);
  localparam integer pulse_int  = `CYC_UP(`WRITE_TO_FLOAT_PS + `DATA_SETUP_PS);
  localparam integer read_int   = `CYC_UP(`READ_ACCESS_PS + `FLOWTHROUGH_PS);
  localparam integer gap_int    = `CYC_UP(`TOKEN_UPDATE_PULSE_PS);
  localparam [3:0]   settle_cyc = settle_int[3:0];
  localparam [3:0]   pulse_cyc  = pulse_int[3:0];
  localparam [3:0]   read_cyc   = read_int[3:0];
  localparam [3:0]   gap_cyc    = gap_int[3:0];

  //------------------------------------------------------------------------
  // States
  //------------------------------------------------------------------------
  localparam [4:0] st_idle   = 5'h01;
  localparam [4:0] st_setup  = 5'h02;
  localparam [4:0] st_strobe = 5'h04;
  localparam [4:0] st_read   = 5'h08;
  localparam [4:0] st_gap    = 5'h10;

  reg  [4:0] state_reg;
  reg        write_reg;
  reg        token_reg;
  reg  [2:0] cont_sync_reg;
  reg  [2:0] irq_sync_reg;
  reg        cont_reg;
  reg        irq_reg;
  reg        load;
  reg  [3:0] load_value;
  wire       expired;

  //------------------------------------------------------------------------
  // Pin input synchronisers
  //------------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cont_sync_reg <= 3'h7;
      irq_sync_reg  <= 3'h7;
      cont_reg      <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      cont_sync_reg <= {cont_sync_reg[1:0], contention_n};
      irq_sync_reg  <= {irq_sync_reg[1:0], mailbox_irq_n};
      if (cont_sync_reg[1] == cont_sync_reg[2]) begin
        cont_reg <= !cont_sync_reg[2];
      end
      if (irq_sync_reg[1] == irq_sync_reg[2]) begin
        irq_reg <= !irq_sync_reg[2];
      end
    end
  end

  assign mbox_irq        = irq_reg;
  assign contention_seen = cont_reg;
  assign cmd_ready       = (state_reg == st_idle);

  wait_timer u_timer (
    .clk        (clk),
    .rstn       (rstn),
    .load       (load),
    .load_value (load_value),
    .expired    (expired)
  );

  //------------------------------------------------------------------------
  // Timer loads
  //------------------------------------------------------------------------
  always @* begin
    load       = 1'b0;
    load_value = 4'h0;
    case (state_reg)
      st_idle: begin
        load       = cmd_valid;
        load_value = settle_cyc;
      end
      st_setup: begin
        load       = expired;
        load_value = write_reg ? pulse_cyc : read_cyc;
      end
      st_strobe, st_read: begin
        load       = expired;
        load_value = gap_cyc;
      end
      default: begin
        load       = 1'b0;
        load_value = 4'h0;
      end
    endcase
  end

  //------------------------------------------------------------------------
  // Access sequencer
  //------------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg          <= st_idle;
      write_reg          <= 1'b0;
      token_reg          <= 1'b0;
      addr               <= {`ADDR_W{1'b0}};
      port_select_n      <= 1'b1;
      token_select_n     <= 1'b1;
      write_strobe_n     <= 1'b1;
      output_enable_n    <= 1'b1;
      high_byte_select_n <= 1'b1;
      low_byte_select_n  <= 1'b1;
      data_out           <= {`DATA_W{1'b0}};
      data_oe            <= 1'b0;
      rsp_valid          <= 1'b0;
      rsp_rdata          <= {`DATA_W{1'b0}};
      rsp_contended      <= 1'b0;
      rsp_token_won      <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        st_idle: begin
          if (cmd_valid) begin
            write_reg <= cmd_write;
            token_reg <= cmd_token;
            // Address moves only while strobe is high
            addr <= cmd_token ? {{(`ADDR_W-`TOKEN_ADDR_W){1'b0}},
                                 cmd_addr[`TOKEN_ADDR_W-1:0]} : cmd_addr;
            // Select asserted before strobe; never both selects
            port_select_n      <= cmd_token;
            token_select_n     <= !cmd_token;
            high_byte_select_n <= cmd_token | !cmd_byte_en[1];
            low_byte_select_n  <= cmd_token | !cmd_byte_en[0];
            output_enable_n    <= cmd_write;
            data_out <= cmd_token ? {{(`DATA_W-1){1'b0}}, !cmd_set_token}
                                  : cmd_wdata;
            state_reg <= st_setup;
          end
        end
        st_setup: begin
          if (expired) begin
            rsp_contended <= cont_reg;
            if (write_reg) begin
              // Strobe falls after select; device floats its outputs
              write_strobe_n <= 1'b0;
              data_oe        <= 1'b1;
              state_reg      <= st_strobe;
            end else begin
              state_reg <= st_read;
            end
          end
        end
        st_strobe: begin
          if (expired) begin
            // Strobe ends the write; data held one more cycle
            write_strobe_n <= 1'b1;
            rsp_valid      <= 1'b1;
            rsp_token_won  <= 1'b0;
            state_reg      <= st_gap;
          end
        end
        st_read: begin
          if (expired) begin
            rsp_rdata     <= data_in;
            rsp_token_won <= token_reg & !data_in[`TOKEN_BIT];
            rsp_valid     <= 1'b1;
            output_enable_n <= 1'b1;
            state_reg     <= st_gap;
          end
        end
        st_gap: begin
          data_oe            <= 1'b0;
          port_select_n      <= 1'b1;
          token_select_n     <= 1'b1;
          output_enable_n    <= 1'b1;
          high_byte_select_n <= 1'b1;
          low_byte_select_n  <= 1'b1;
          if (expired) begin
            state_reg <= st_idle;
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end
endmodule // dpram_port_host

/* File: core/wait_timer.v */
// Down counter that times the phases of a port access
`timescale 1ns/10ps
module wait_timer (
  input  wire       clk,
  input  wire       rstn,
  input  wire       load,
  input  wire [3:0] load_value,
  output wire       expired
);
  reg [3:0] count_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 4'h0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end
  end

  assign expired = (count_reg == 4'h0);
endmodule // wait_timer

/* File: include/dpram_host_consts.vh */
// Constants for the dual-port memory port controller
`ifndef DPRAM_HOST_CONSTS_VH
`define DPRAM_HOST_CONSTS_VH

`define ADDR_W            16
`define DATA_W            16
`define TOKEN_ADDR_W      3
`define RIGHT_MBOX_ADDR   16'hffff
`define LEFT_MBOX_ADDR    16'hfffe
`define TOKEN_BIT         0
`define CLK_PERIOD_PS     8000
`define WRITE_PULSE_MIN_PS      22000
`define WRITE_TO_FLOAT_PS       15000
`define DATA_SETUP_PS           15000
`define FLOWTHROUGH_PS          35000
`define MATCH_TO_FLAG_PS        20000
`define SELECT_TO_FLAG_PS       20000
`define TOKEN_UPDATE_PULSE_PS   12000
`define READ_ACCESS_PS          25000
`define CYC_UP(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif
